// file: verilog/dlm_door_lock_fault_monitor.sv
// Door, gate, lock and zone fault monitor with APB registers.
// Assumes field inputs are asynchronous contact levels, active high,
// and one 50 MHz clock with asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module dlm_door_lock_fault_monitor
#(
    parameter int TICK_CYC   = dlm_pkg::TICK_CYCLES,
    parameter int PROT_MS    = dlm_pkg::PROT_TIME_MS,
    parameter int DEB_MS     = dlm_pkg::DEBOUNCE_MS,
    parameter int CTEST_MS   = dlm_pkg::CYCLE_TEST_MS
)
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Field contacts
    input  wire logic [dlm_pkg::NIN-1:0] field_in,
    // Outputs to car and door open requests
    output logic                    front_door_open_function,
    output logic                    rear_door_open_function,
    input  wire logic               front_open_request,
    input  wire logic               rear_open_request,
    output logic                    retiring_cam_relay,
    output logic                    motor_contactor,
    output logic                    brake_contactor,
    output logic                    leave_permit,
    output logic                    irq
);
    import dlm_pkg::*;

    // Counter widths below bound the timing parameters
    if (TICK_CYC < 2 || PROT_MS < 2 || DEB_MS < 1 || CTEST_MS < 2 ||
        TICK_CYC > 2**26 || PROT_MS > 2**17 - 1 || DEB_MS > 256 ||
        CTEST_MS > 2**16)
    begin
        $error("dlm: timing parameters out of range");
    end

    // ------------------------------------------------------------
    // Input synchronise and debounce
    // ------------------------------------------------------------
    logic [NIN-1:0] s1_reg, s2_reg, s3_reg, deb_reg;
    logic [NIN-1:0][7:0] dcnt_reg;
    logic tick;
    logic [25:0] tcnt_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= field_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Millisecond tick drives all long timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tcnt_reg <= '0;
        else if (tick)
            tcnt_reg <= '0;
        else
            tcnt_reg <= tcnt_reg + 26'h1;
    end
    assign tick = (tcnt_reg == 26'(TICK_CYC - 1));

    // A level counts only after stages 2 and 3 agree and hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deb_reg  <= '0;
            dcnt_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NIN; i++)
            begin
                if (s2_reg[i] != s3_reg[i] || s3_reg[i] == deb_reg[i])
                    dcnt_reg[i] <= '0;
                else if (tick)
                begin
                    if (dcnt_reg[i] == 8'(DEB_MS - 1))
                    begin
                        deb_reg[i]  <= s3_reg[i];
                        dcnt_reg[i] <= '0;
                    end
                    else
                        dcnt_reg[i] <= dcnt_reg[i] + 8'h1;
                end
            end
        end
    end

    logic door_closed_contact, door_close_limit;
    logic front_door_position_monitor, rear_door_position_monitor;
    logic run_demand, door_locked_input, front_open_limit, rear_open_limit;
    logic front_gate_switch, rear_gate_switch, front_lock_input;
    logic rear_lock_input, safety_string_on, front_zone_sensor;
    logic rear_zone_sensor, drive_fault_input, bottom_access_door_contact;
    logic rear_close_limit_contact, cartop_inspection_input;
    logic inspection, computer_reset, fault_reset, access_sw;

    assign door_closed_contact         = deb_reg[IN_DCC];
    assign door_close_limit            = deb_reg[IN_DCLIM];
    assign front_door_position_monitor = deb_reg[IN_PMF];
    assign rear_door_position_monitor  = deb_reg[IN_PMR];
    assign run_demand                  = deb_reg[IN_RUN];
    assign door_locked_input           = deb_reg[IN_LOCKED];
    assign front_open_limit            = deb_reg[IN_OLF];
    assign rear_open_limit             = deb_reg[IN_OLR];
    assign front_gate_switch           = deb_reg[IN_GSF];
    assign rear_gate_switch            = deb_reg[IN_GSR];
    assign front_lock_input            = deb_reg[IN_LKF];
    assign rear_lock_input             = deb_reg[IN_LKR];
    assign safety_string_on            = deb_reg[IN_SAF];
    assign front_zone_sensor           = deb_reg[IN_ZF];
    assign rear_zone_sensor            = deb_reg[IN_ZR];
    assign drive_fault_input           = deb_reg[IN_DRV];
    assign bottom_access_door_contact  = deb_reg[IN_BAC];
    assign rear_close_limit_contact    = deb_reg[IN_RCL];
    assign cartop_inspection_input     = deb_reg[IN_CTI];
    assign inspection                  = deb_reg[IN_INSP];
    assign computer_reset              = deb_reg[IN_CRST];
    assign fault_reset                 = deb_reg[IN_FRST];
    assign access_sw = deb_reg[IN_ACC_UP] | deb_reg[IN_ACC_DN];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [NEV-1:0] status_reg, mask_reg, ev;
    logic wr_en, rd_en;
    logic [3:0] fail_cnt_reg;
    logic shutdown_reg, zone_off_reg, insp_d_reg;
    dlm_ct_t ct_state_reg;

    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pslverr = psel & penable & (paddr > OFS_COUNT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= '0;
        end
        else if (wr_en && paddr == OFS_CTRL)
            ctrl_reg <= pwdata & 32'h0000_00f1;
        else if (wr_en && paddr == OFS_MASK)
            mask_reg <= pwdata[NEV-1:0];
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= '0;
        else if (wr_en && paddr == OFS_STATUS)
            status_reg <= (status_reg & ~pwdata[NEV-1:0]) | ev;
        else
            status_reg <= status_reg | ev;
    end

    assign irq = |(status_reg & mask_reg);

    logic bottom_access_fail, bottom_rear_fail;
    logic [31:0] live;
    assign live = {26'h0, zone_off_reg, shutdown_reg,
                   bottom_rear_fail, bottom_access_fail,
                   (ct_state_reg == DLM_CT_TEST),
                   cartop_inspection_input};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                OFS_CTRL:   prdata <= ctrl_reg;
                OFS_STATUS: prdata <= 32'(status_reg);
                OFS_MASK:   prdata <= 32'(mask_reg);
                OFS_LIVE:   prdata <= live;
                OFS_COUNT:  prdata <= 32'(fail_cnt_reg);
                default:    prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Door close protection
    // ------------------------------------------------------------
    logic doors_closed, dclose_arm, dclose_clr;
    logic [16:0] dc_ms_reg;
    logic dc_fault_reg;
    logic [3:0] limit;

    assign doors_closed = door_closed_contact |
                          (~door_close_limit & front_door_position_monitor);
    assign dclose_arm   = doors_closed & run_demand & ~door_locked_input;
    assign dclose_clr   = door_locked_input | inspection | computer_reset;
    assign limit        = ctrl_reg[CTRL_LIM_LSB +: CTRL_LIM_W];
    assign retiring_cam_relay = ctrl_reg[CTRL_CAM_EN] & run_demand &
                                doors_closed & ~shutdown_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dc_ms_reg <= '0;
        else if (!dclose_arm || dc_fault_reg)
            dc_ms_reg <= '0;
        else if (tick)
            dc_ms_reg <= dc_ms_reg + 17'h1;
    end

    logic dc_expire;
    assign dc_expire = dclose_arm & ~dc_fault_reg &
                       (dc_ms_reg == 17'(PROT_MS - 1)) & tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dc_fault_reg <= 1'b0;
        else if (dc_expire)
            dc_fault_reg <= 1'b1;
        else if (dclose_clr)
            dc_fault_reg <= 1'b0;
    end

    // Consecutive count resets on lock; shutdown holds until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fail_cnt_reg <= '0;
            shutdown_reg <= 1'b0;
        end
        else
        begin
            if (dc_expire)
                fail_cnt_reg <= fail_cnt_reg + 4'h1;
            else if (door_locked_input || computer_reset)
                fail_cnt_reg <= '0;
            if (dc_expire && fail_cnt_reg + 4'h1 >= limit)
                shutdown_reg <= 1'b1;
            else if (computer_reset)
                shutdown_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Door open protection, one timer per side
    // ------------------------------------------------------------
    logic [1:0] open_req, open_fn_reg, open_exp;
    logic [1:0][16:0] do_ms_reg;
    assign open_req = {rear_open_request, front_open_request};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            open_fn_reg <= '0;
            do_ms_reg   <= '0;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (!open_req[s])
                begin
                    open_fn_reg[s] <= 1'b0;
                    do_ms_reg[s]   <= '0;
                end
                else if (open_exp[s])
                    open_fn_reg[s] <= 1'b0;
                else if (do_ms_reg[s] == '0 && !open_fn_reg[s])
                begin
                    open_fn_reg[s] <= 1'b1;
                    do_ms_reg[s]   <= 17'h1;
                end
                else if (tick && open_fn_reg[s])
                    do_ms_reg[s] <= do_ms_reg[s] + 17'h1;
            end
        end
    end
    // Request must drop before the function can return
    always_comb
    begin
        for (int s = 0; s < 2; s++)
            open_exp[s] = open_fn_reg[s] & tick &
                          (do_ms_reg[s] == 17'(PROT_MS));
    end
    assign front_door_open_function = open_fn_reg[0];
    assign rear_door_open_function  = open_fn_reg[1];

    // ------------------------------------------------------------
    // Run tracking and door zone checks
    // ------------------------------------------------------------
    logic run_d_reg, seen_zone_reg, zf_low_reg, zr_low_reg, run_end;
    assign run_end = run_d_reg & ~run_demand;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_d_reg     <= 1'b0;
            seen_zone_reg <= 1'b0;
            zf_low_reg    <= 1'b0;
            zr_low_reg    <= 1'b0;
            insp_d_reg    <= 1'b0;
        end
        else
        begin
            run_d_reg  <= run_demand;
            insp_d_reg <= inspection;
            if (run_demand && !run_d_reg)
            begin
                seen_zone_reg <= 1'b0;
                zf_low_reg    <= 1'b0;
                zr_low_reg    <= 1'b0;
            end
            else if (run_demand)
            begin
                seen_zone_reg <= seen_zone_reg | front_zone_sensor |
                                 rear_zone_sensor;
                zf_low_reg <= zf_low_reg | ~front_zone_sensor;
                zr_low_reg <= zr_low_reg | ~rear_zone_sensor;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            zone_off_reg <= 1'b0;
        else if (run_end && !seen_zone_reg)
            zone_off_reg <= 1'b1;
        else if (fault_reset || (inspection != insp_d_reg))
            zone_off_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Cycle test and contactors
    // ------------------------------------------------------------
    logic [15:0] ct_ms_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ct_state_reg <= DLM_CT_IDLE;
            ct_ms_reg    <= '0;
        end
        else
        begin
            unique case (ct_state_reg)
                DLM_CT_IDLE:
                    if (run_demand && !drive_fault_input && !shutdown_reg)
                    begin
                        ct_state_reg <= DLM_CT_TEST;
                        ct_ms_reg    <= '0;
                    end
                DLM_CT_TEST:
                    if (!run_demand || drive_fault_input || shutdown_reg)
                        ct_state_reg <= DLM_CT_IDLE;
                    else if (tick && ct_ms_reg == 16'(CTEST_MS - 1))
                        ct_state_reg <= DLM_CT_DONE;
                    else if (tick)
                        ct_ms_reg <= ct_ms_reg + 16'h1;
                DLM_CT_DONE:
                    if (!run_demand || drive_fault_input || shutdown_reg)
                        ct_state_reg <= DLM_CT_IDLE;
                default:
                    ct_state_reg <= DLM_CT_IDLE;
            endcase
        end
    end

    // Motor contactor alone during test, brake added when done; drive fault drops both at once
    assign motor_contactor = ~drive_fault_input & ~shutdown_reg &
        ((ct_state_reg == DLM_CT_TEST) | (ct_state_reg == DLM_CT_DONE));
    assign brake_contactor = motor_contactor &
                             (ct_state_reg == DLM_CT_DONE);
    assign leave_permit    = (ct_state_reg == DLM_CT_DONE) &
                             ~drive_fault_input & ~shutdown_reg;

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    assign bottom_access_fail = inspection & access_sw &
                                ~bottom_access_door_contact;
    assign bottom_rear_fail   = inspection & access_sw &
                                ~rear_close_limit_contact;

    always_comb
    begin
        ev = '0;
        ev[EV_DCLOSE]   = dc_expire;
        ev[EV_SHUTDOWN] = shutdown_reg;
        ev[EV_DOPEN_F]  = open_exp[0];
        ev[EV_DOPEN_R]  = open_exp[1];
        ev[EV_OLIM_F]   = (front_door_position_monitor | front_gate_switch)
                          & ~front_open_limit;
        ev[EV_OLIM_R]   = (rear_door_position_monitor | rear_gate_switch)
                          & ~rear_open_limit;
        ev[EV_LOCK_F]   = front_lock_input & ~front_gate_switch;
        ev[EV_LOCK_R]   = rear_lock_input & ~rear_gate_switch;
        ev[EV_PMON_F]   = safety_string_on &
            (door_locked_input ^ front_door_position_monitor);
        ev[EV_PMON_R]   = safety_string_on &
            (door_locked_input ^ rear_door_position_monitor);
        ev[EV_ZONE_OFF] = run_end & ~seen_zone_reg;
        ev[EV_ZONE_ON]  = run_end & ~(zf_low_reg & zr_low_reg);
        ev[EV_DRIVE]    = drive_fault_input;
    end

    logic unused_ok;
    assign unused_ok = rd_en;

endmodule

`default_nettype wire

// file: include/dlm_pkg.sv
// Package for the door and lock fault monitor: register map, fields,
// reset values and timing constants.
// Assumes a 50 MHz pclk and a 32-bit APB slave port.
package dlm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50000000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int PROT_TIME_S     = 60;
    localparam int PROT_TIME_MS    = PROT_TIME_S * 1000;
    localparam int DEBOUNCE_MS     = 10;
    localparam int DCLOSE_LIMIT_DEF = 4;
    localparam int CYCLE_TEST_MS   = 200;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_LIVE   = 8'h0c;
    localparam logic [7:0] OFS_COUNT  = 8'h10;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_CAM_EN     = 0;
    localparam int CTRL_LIM_LSB    = 4;
    localparam int CTRL_LIM_W      = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0040;

    // ------------------------------------------------------------
    // Sticky event bits
    // ------------------------------------------------------------
    localparam int NEV          = 13;
    localparam int EV_DCLOSE    = 0;
    localparam int EV_SHUTDOWN  = 1;
    localparam int EV_DOPEN_F   = 2;
    localparam int EV_DOPEN_R   = 3;
    localparam int EV_OLIM_F    = 4;
    localparam int EV_OLIM_R    = 5;
    localparam int EV_LOCK_F    = 6;
    localparam int EV_LOCK_R    = 7;
    localparam int EV_PMON_F    = 8;
    localparam int EV_PMON_R    = 9;
    localparam int EV_ZONE_OFF  = 10;
    localparam int EV_ZONE_ON   = 11;
    localparam int EV_DRIVE     = 12;

    // ------------------------------------------------------------
    // Live view bits
    // ------------------------------------------------------------
    localparam int LV_CARTOP    = 0;
    localparam int LV_CYCTEST   = 1;
    localparam int LV_ACC_B     = 2;
    localparam int LV_ACC_BR    = 3;
    localparam int LV_SHUTDOWN  = 4;
    localparam int LV_ZONE_OFF  = 5;

    // ------------------------------------------------------------
    // Field input index (synchroniser bank)
    // ------------------------------------------------------------
    localparam int NIN          = 24;
    localparam int IN_DCC       = 0;
    localparam int IN_DCLIM     = 1;
    localparam int IN_PMF       = 2;
    localparam int IN_PMR       = 3;
    localparam int IN_RUN       = 4;
    localparam int IN_LOCKED    = 5;
    localparam int IN_OLF       = 6;
    localparam int IN_OLR       = 7;
    localparam int IN_GSF       = 8;
    localparam int IN_GSR       = 9;
    localparam int IN_LKF       = 10;
    localparam int IN_LKR       = 11;
    localparam int IN_SAF       = 12;
    localparam int IN_ZF        = 13;
    localparam int IN_ZR        = 14;
    localparam int IN_DRV       = 15;
    localparam int IN_BAC       = 16;
    localparam int IN_RCL       = 17;
    localparam int IN_CTI       = 18;
    localparam int IN_INSP      = 19;
    localparam int IN_CRST      = 20;
    localparam int IN_FRST      = 21;
    localparam int IN_ACC_UP    = 22;
    localparam int IN_ACC_DN    = 23;

    // Cycle test states
    typedef enum logic [1:0] {
        DLM_CT_IDLE = 2'b00,
        DLM_CT_TEST = 2'b01,
        DLM_CT_DONE = 2'b10
    } dlm_ct_t;

endpackage

// file: test/dlm_properties.sv
// Port checker for the door and lock fault monitor.
// Assumes the timing parameters are handed on by the bind.
`timescale 1ns/1ns
`default_nettype none
module dlm_properties
#(
    parameter int TICK_CYC = 4,
    parameter int PROT_MS  = 5,
    parameter int DEB_MS   = 1
)
(
    // Clock and bus
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic [7:0]               paddr,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // Car side
    input wire logic [dlm_pkg::NIN-1:0]  field_in,
    input wire logic                     front_open_request,
    input wire logic                     rear_open_request,
    input wire logic                     front_door_open_function,
    input wire logic                     rear_door_open_function,
    input wire logic                     motor_contactor,
    input wire logic                     brake_contactor,
    input wire logic                     leave_permit
);
    import dlm_pkg::*;
    // Sync flops plus debounce, with margin for tick phase
    localparam int DRV_LAT = (DEB_MS + 2) * TICK_CYC + 8;
    localparam int DOF_MAX = (PROT_MS + 2) * TICK_CYC;
    int drv_cnt;
    int dof_cnt;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            drv_cnt <= 0;
            dof_cnt <= 0;
        end
        else
        begin
            drv_cnt <= field_in[IN_DRV] ? drv_cnt + 1 : 0;
            dof_cnt <= front_door_open_function ? dof_cnt + 1 : 0;
        end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (pready)
        else $error("pready low");
    AST_SLVERR: assert property (psel && penable |->
        pslverr == (paddr > 8'h10)) else $error("pslverr wrong");
    AST_DRV_DROP: assert property (drv_cnt > DRV_LAT |->
        !motor_contactor && !brake_contactor) else $error("no stop");
    AST_PERMIT: assert property (leave_permit |->
        motor_contactor && brake_contactor) else $error("permit bad");
    AST_TEST_FIRST: assert property ($rose(leave_permit) |->
        $past(motor_contactor) && !$past(brake_contactor))
        else $error("no cycle test");
    AST_DOF_OFF: assert property (!front_open_request |=>
        !front_door_open_function) else $error("front open stuck");
    AST_RDOF_OFF: assert property (!rear_open_request |=>
        !rear_door_open_function) else $error("rear open stuck");
    AST_DOF_LIMIT: assert property (dof_cnt <= DOF_MAX)
        else $error("open function too long");
endmodule
bind dlm_door_lock_fault_monitor dlm_properties #(.TICK_CYC(TICK_CYC),
    .PROT_MS(PROT_MS), .DEB_MS(DEB_MS)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .field_in(field_in),
    .front_open_request(front_open_request),
    .rear_open_request(rear_open_request),
    .front_door_open_function(front_door_open_function),
    .rear_door_open_function(rear_door_open_function),
    .motor_contactor(motor_contactor), .brake_contactor(brake_contactor),
    .leave_permit(leave_permit));
`default_nettype wire

// file: test/dlm_field_model.sv
// Car and hoistway contacts: levels reach the pins one or seven cycles late.
// Assumes the bench states the wanted contact levels.
`timescale 1ns/1ns
`default_nettype none
module dlm_field_model
(
    // Clock and command
    input  wire logic        pclk,
    input  wire logic [23:0] want,
    input  wire logic        slow,
    // Contacts
    output logic [23:0]      field_in
);
    logic [23:0] dly [6];
    initial field_in = 24'h0;
    always @(posedge pclk)
    begin
        dly[0] <= want;
        for (int i = 1; i < 6; i++)
            dly[i] <= dly[i-1];
        field_in <= slow ? dly[5] : want;
    end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the door and lock fault monitor.
// Assumes the package, checker and contact model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dlm_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, fdof, rdof, cam, mot, brk, perm, irq;
    logic        freq = 0, rreq = 0, slow = 0;
    logic [23:0] want = 24'h0, field;
    int          failures = 0, compares = 0, seed = 32'h6c265453;
    dlm_door_lock_fault_monitor #(.TICK_CYC(4), .PROT_MS(5), .DEB_MS(1),
        .CTEST_MS(3)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_in(field), .front_door_open_function(fdof),
        .rear_door_open_function(rdof), .front_open_request(freq),
        .rear_open_request(rreq), .retiring_cam_relay(cam),
        .motor_contactor(mot), .brake_contactor(brk), .leave_permit(perm),
        .irq(irq));
    dlm_field_model u_model (.pclk(pclk), .want(want), .slow(slow),
        .field_in(field));
    initial forever #10 pclk = ~pclk;
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Level faults expected for a set of contacts
    function automatic logic [31:0] lvl(input logic [23:0] f);
        lvl = 32'h0;
        lvl[EV_OLIM_F] = (f[IN_PMF] | f[IN_GSF]) & !f[IN_OLF];
        lvl[EV_OLIM_R] = (f[IN_PMR] | f[IN_GSR]) & !f[IN_OLR];
        lvl[EV_LOCK_F] = f[IN_LKF] & !f[IN_GSF];
        lvl[EV_LOCK_R] = f[IN_LKR] & !f[IN_GSR];
        lvl[EV_PMON_F] = f[IN_SAF] & (f[IN_LOCKED] ^ f[IN_PMF]);
        lvl[EV_PMON_R] = f[IN_SAF] & (f[IN_LOCKED] ^ f[IN_PMR]);
    endfunction
    task automatic final_report;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        presetn <= 1;
    end
    initial
    begin
        cyc(20000);
        failures++;
        final_report;
    end
    initial
    begin
        @(posedge presetn);
        apb(0, OFS_CTRL, 0);
        chk(rd, CTRL_RESET);
        apb(0, 8'h14, 0);
        chk(rd, 0);
        apb(1, OFS_MASK, 32'h1fff);
        // First pass is the lone front lock corner
        for (int i = 0; i < 16; i++)
        begin
            want <= i == 0 ? 24'h400 : 24'($random(seed)) & 24'h1fec;
            slow <= 1'($random(seed));
            cyc(30);
            apb(1, OFS_STATUS, 32'hffffffff);
            apb(0, OFS_STATUS, 0);
            chk(rd, lvl(want));
            chk(32'(irq), 32'(|lvl(want)));
        end
        slow <= 0;
        want <= 24'h11;
        apb(1, OFS_CTRL, 32'h41);
        cyc(40);
        chk(32'({cam, perm}), 2'b11);
        apb(0, OFS_STATUS, 0);
        chk(32'(rd[EV_DCLOSE]), 1);
        apb(0, OFS_COUNT, 0);
        chk(rd, 1);
        want <= 24'h8011;
        cyc(25);
        chk(32'({mot, brk, perm}), 0);
        want <= 24'h0;
        cyc(25);
        apb(0, OFS_STATUS, 0);
        chk(32'(rd[12:10]), 3'b101);
        want <= 24'h6c0000;
        cyc(25);
        apb(0, OFS_LIVE, 0);
        chk(32'({rd[LV_ZONE_OFF], rd[LV_CARTOP]}), 2'b01);
        chk(32'(rd[LV_ACC_BR:LV_ACC_B]), 2'b11);
        apb(1, OFS_STATUS, 32'hffffffff);
        want <= 24'h6010;
        cyc(30);
        want <= 24'h6000;
        cyc(25);
        apb(0, OFS_STATUS, 0);
        chk(32'(rd[11:10]), 2'b10);
        freq <= 1;
        rreq <= 1;
        cyc(3);
        chk(32'({fdof, rdof}), 2'b11);
        cyc(40);
        apb(0, OFS_STATUS, 0);
        chk(32'({fdof, rdof, rd[3:2]}), 4'b0011);
        freq <= 0;
        rreq <= 0;
        final_report;
    end
endmodule
`default_nettype wire
